// ---- mcr_consts.svh ----
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// Channel count and width of the channel index carried with each output
`define MCR_NUM_CH      4
`define MCR_CH_W        2

// Sample widths at the two streaming ports
`define MCR_DIN_W       18
`define MCR_DOUT_W      18

// Filter shape: stages per section, rate change, comb differential delay
`define MCR_NUM_STG     4
`define MCR_RATE        16
`define MCR_DIFF_DLY    1

// Depth of the input buffer in words
`define MCR_FIFO_DEPTH  8

// Reset values of the output flags
`define MCR_RST_VALID   1'b0
`define MCR_RST_SYNC    1'b0

`endif

// ---- mcr_pkg.sv ----
package mcr_pkg;

  `include "mcr_consts.svh"

  typedef enum logic [0:0]
  {
    MCR_INTERP = 1'b0,
    MCR_DECIM  = 1'b1
  } mcr_mode_t;

  // Input side: waits for a full channel group, then drains it back to back
  typedef enum logic [1:0]
  {
    MCR_TK_IDLE  = 2'b01,
    MCR_TK_BURST = 2'b10
  } mcr_take_t;

  // Output side of the interpolator: idle or streaming high-rate samples
  typedef enum logic [1:0]
  {
    MCR_OG_IDLE = 2'b01,
    MCR_OG_RUN  = 2'b10
  } mcr_gen_t;

  typedef struct packed
  {
    logic signed [`MCR_DOUT_W-1:0] data;
    logic        [`MCR_CH_W-1:0]   chan;
    logic                          sync;
  } mcr_out_t;

endpackage

// ---- mcr_fifo.sv ----
`timescale 1ns/1ps
`include "mcr_consts.svh"

module mcr_fifo
  import mcr_pkg::*;
#(
  parameter int W     = `MCR_DIN_W,
  parameter int DEPTH = `MCR_FIFO_DEPTH
)
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  input  wire logic [W-1:0]               in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [W-1:0]                    out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH):0]          count
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          ready_r;
  logic          push;
  logic          pop;

  // A word offered while ready is low is dropped
  assign push      = in_valid & ready_r;
  assign pop       = out_ready & (count_r != '0);
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready  = ready_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign count     = count_r;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Ready is registered from the next count so the flag leaves a flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

endmodule

// ---- mcr_cic_filter.sv ----
`timescale 1ns/1ps
`include "mcr_consts.svh"
module mcr_cic_filter
  import mcr_pkg::*;
#(
  parameter mcr_mode_t MODE   = MCR_DECIM,
  parameter int        NCH    = `MCR_NUM_CH,
  parameter int        NSTG   = `MCR_NUM_STG,
  parameter int        RATE   = `MCR_RATE,
  parameter int        M      = `MCR_DIFF_DLY,
  parameter int        FDEPTH = `MCR_FIFO_DEPTH
)
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic signed [`MCR_DIN_W-1:0] in_sample,
  input  wire logic                         input_valid_strobe,
  output logic                              ready_for_data,
  output logic                              out_valid,
  output mcr_out_t                          out_sample
);

  localparam int  DIN_W  = `MCR_DIN_W;
  localparam int  DOUT_W = `MCR_DOUT_W;
  localparam int  CH_W   = `MCR_CH_W;
  localparam int  RW     = (RATE > 1) ? $clog2(RATE) : 1;
  localparam int  FCW    = $clog2(FDEPTH) + 1;
  // Register growth of the full cascade; wrap-around inside is harmless
  localparam int  ACC_W  = DIN_W + NSTG * $clog2(RATE * M);
  localparam bit  IS_DEC = (MODE == MCR_DECIM);

  typedef logic signed [ACC_W-1:0] acc_t;

  // Input buffer
  logic [DIN_W-1:0] fifo_data;
  logic             fifo_valid;
  logic [FCW-1:0]   fifo_count;
  logic             pop;

  // Input group taker
  mcr_take_t        take_r;
  logic [CH_W-1:0]  in_ch_r;
  logic             last_in;
  logic             can_take;

  // Decimation phase
  logic [RW-1:0]    dec_cnt_r;

  // Interpolator output engine
  mcr_gen_t         gen_r;
  logic [CH_W-1:0]  oc_r;
  logic [RW-1:0]    ph_r;
  logic             last_oc;
  logic             last_ph;
  acc_t             pend_r [NCH];
  logic             pend_full_r;
  logic             pend_clr;
  logic             pend_set;

  // Shared stage chains
  acc_t             int_in;
  logic [CH_W-1:0]  int_ch;
  logic             int_en;
  acc_t             comb_in;
  logic [CH_W-1:0]  comb_ch;
  logic             comb_en;
  acc_t             int_v  [NSTG+1];
  acc_t             comb_v [NSTG+1];
  acc_t             din_ext;

  mcr_fifo #(
    .W     (DIN_W),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (input_valid_strobe),
    .in_data   (in_sample),
    .in_ready  (ready_for_data),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop),
    .count     (fifo_count)
  );

  assign din_ext = {{(ACC_W-DIN_W){fifo_data[DIN_W-1]}}, fifo_data};

  // A group is drained only once fully buffered, so output bursts stay gap free
  assign pop      = (take_r == MCR_TK_BURST) & fifo_valid;
  assign last_in  = (in_ch_r == CH_W'(NCH - 1));
  assign can_take = IS_DEC ? 1'b1 : ~pend_full_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      take_r  <= MCR_TK_IDLE;
      in_ch_r <= '0;
    end
    else
    begin
      case (take_r)
        MCR_TK_IDLE:
        begin
          in_ch_r <= '0;
          if (can_take && (fifo_count >= FCW'(NCH)))
          begin
            take_r <= MCR_TK_BURST;
          end
        end
        MCR_TK_BURST:
        begin
          // Samples arrive in channel order, one per cycle
          if (pop)
          begin
            in_ch_r <= last_in ? '0 : in_ch_r + 1'b1;
            if (last_in)
            begin
              take_r <= MCR_TK_IDLE;
            end
          end
        end
        default:
        begin
          take_r  <= MCR_TK_IDLE;
          in_ch_r <= '0;
        end
      endcase
    end
  end

  // Down-sampler: keep one group out of every RATE groups
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dec_cnt_r <= '0;
    end
    else if (IS_DEC && pop && last_in)
    begin
      dec_cnt_r <= (dec_cnt_r == RW'(RATE - 1)) ? '0 : dec_cnt_r + 1'b1;
    end
  end

  // Stage routing for the two structures
  always_comb
  begin
    if (IS_DEC)
    begin
      int_in  = din_ext;
      int_ch  = in_ch_r;
      int_en  = pop;
      comb_in = int_v[NSTG];
      comb_ch = in_ch_r;
      comb_en = pop && (dec_cnt_r == RW'(RATE - 1));
    end
    else
    begin
      comb_in = din_ext;
      comb_ch = in_ch_r;
      comb_en = pop;
      // Up-sampler stuffs zeros after the held comb output
      int_in  = (ph_r == '0) ? pend_r[oc_r] : '0;
      int_ch  = oc_r;
      int_en  = (gen_r == MCR_OG_RUN);
    end
  end

  assign int_v[0]  = int_in;
  assign comb_v[0] = comb_in;

  // One integrator and one comb per stage, state held per channel
  genvar k;
  generate
    for (k = 0; k < NSTG; k++)
    begin : g_stage
      acc_t acc_r [NCH];
      acc_t dly_r [NCH][M];

      assign int_v[k+1]  = acc_t'(int_v[k] + acc_r[int_ch]);
      // Comb subtracts its own input from M samples back
      assign comb_v[k+1] = acc_t'(comb_v[k] - dly_r[comb_ch][M-1]);

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          for (int c = 0; c < NCH; c++)
          begin
            acc_r[c] <= '0;
          end
        end
        else if (int_en)
        begin
          acc_r[int_ch] <= int_v[k+1];
        end
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          for (int c = 0; c < NCH; c++)
          begin
            for (int j = 0; j < M; j++)
            begin
              dly_r[c][j] <= '0;
            end
          end
        end
        else if (comb_en)
        begin
          dly_r[comb_ch][0] <= comb_v[k];
          for (int j = 1; j < M; j++)
          begin
            dly_r[comb_ch][j] <= dly_r[comb_ch][j-1];
          end
        end
      end
    end
  endgenerate

  // Interpolator: comb results wait here until the engine reads phase zero
  assign last_oc  = (oc_r == CH_W'(NCH - 1));
  assign last_ph  = (ph_r == RW'(RATE - 1));
  assign pend_set = !IS_DEC && pop && last_in;
  assign pend_clr = (gen_r == MCR_OG_RUN) && (ph_r == '0) && last_oc;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        pend_r[c] <= '0;
      end
    end
    else if (!IS_DEC && pop)
    begin
      pend_r[in_ch_r] <= comb_v[NSTG];
    end
  end

  // A new group landing in the clearing cycle must not be lost
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_full_r <= 1'b0;
    end
    else if (pend_set)
    begin
      pend_full_r <= 1'b1;
    end
    else if (pend_clr)
    begin
      pend_full_r <= 1'b0;
    end
  end

  // Output stays continuous as long as the next group is ready by frame end
  always_ff @(posedge clk)
  begin
    if (rst || IS_DEC)
    begin
      gen_r <= MCR_OG_IDLE;
      oc_r  <= '0;
      ph_r  <= '0;
    end
    else
    begin
      case (gen_r)
        MCR_OG_IDLE:
        begin
          oc_r <= '0;
          ph_r <= '0;
          if (pend_full_r)
          begin
            gen_r <= MCR_OG_RUN;
          end
        end
        MCR_OG_RUN:
        begin
          oc_r <= last_oc ? '0 : oc_r + 1'b1;
          if (last_oc)
          begin
            ph_r <= last_ph ? '0 : ph_r + 1'b1;
            if (last_ph && !pend_full_r)
            begin
              gen_r <= MCR_OG_IDLE;
            end
          end
          // Without a gap the next frame starts right away
        end
        default:
        begin
          gen_r <= MCR_OG_IDLE;
          oc_r  <= '0;
          ph_r  <= '0;
        end
      endcase
    end
  end

  // Output register; truncation keeps the top bits of the cascade
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid       <= `MCR_RST_VALID;
      out_sample.data <= '0;
      out_sample.chan <= '0;
      out_sample.sync <= `MCR_RST_SYNC;
    end
    else if (IS_DEC)
    begin
      // One valid cycle per channel of a kept group, idle otherwise
      out_valid       <= comb_en;
      out_sample.data <= comb_v[NSTG][ACC_W-1 -: DOUT_W];
      out_sample.chan <= in_ch_r;
      out_sample.sync <= comb_en && (in_ch_r == '0);
    end
    else
    begin
      out_valid       <= int_en;
      out_sample.data <= int_v[NSTG][ACC_W-1 -: DOUT_W];
      out_sample.chan <= oc_r;
      out_sample.sync <= int_en && (oc_r == '0);
    end
  end

endmodule

// ---- mcr_cic_filter_assertions.sv ----
`timescale 1ns/1ps
`include "mcr_consts.svh"

module mcr_cic_filter_assertions
  import mcr_pkg::*;
#(
  parameter mcr_mode_t MODE = MCR_DECIM,
  parameter int        NCH  = `MCR_NUM_CH,
  parameter int        RATE = `MCR_RATE
)
(
  input wire logic     clk,
  input wire logic     rst,
  input wire logic     input_valid_strobe,
  input wire logic     ready_for_data,
  input wire logic     out_valid,
  input wire mcr_out_t out_sample
);
  logic [15:0] taken_r;

  // Saturates so a long run cannot wrap it back below the first-output threshold
  always_ff @(posedge clk)
    if (rst)
      taken_r <= '0;
    else if (input_valid_strobe && ready_for_data && taken_r != 16'hffff)
      taken_r <= taken_r + 16'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    !out_valid [*8];
  endsequence
  sequence s_run;
    out_valid [*8];
  endsequence

  property p_sync_first;
    out_sample.sync |-> out_valid && out_sample.chan == 2'h0;
  endproperty
  property p_zero_sync;
    out_valid && out_sample.chan == 2'h0 |-> out_sample.sync;
  endproperty
  property p_chan_step;
    out_valid && out_sample.chan != 2'(NCH - 1)
      |=> out_valid && out_sample.chan == $past(out_sample.chan) + 2'h1;
  endproperty
  property p_group_start;
    $rose(out_valid) |-> out_sample.chan == 2'h0;
  endproperty
  property p_decim_gap;
    MODE == MCR_DECIM && out_valid && out_sample.chan == 2'(NCH - 1) |=> s_quiet;
  endproperty
  property p_interp_run;
    MODE == MCR_INTERP && $rose(out_valid) |-> s_run;
  endproperty
  property p_wake;
    $fell(rst) |-> ##[0:2] ready_for_data;
  endproperty
  property p_needs_input;
    out_valid |-> taken_r >= (MODE == MCR_DECIM ? RATE * NCH : NCH);
  endproperty

  a_sync_first: assert property (p_sync_first) else $error("sync without channel zero");
  a_zero_sync: assert property (p_zero_sync) else $error("channel zero without sync");
  a_chan_step: assert property (p_chan_step) else $error("channel sequence broken");
  a_group_start: assert property (p_group_start) else $error("group not at zero");
  a_decim_gap: assert property (p_decim_gap) else $error("no gap after burst");
  a_interp_run: assert property (p_interp_run) else $error("frame not continuous");
  a_wake: assert property (p_wake) else $error("ready not raised");
  a_needs_input: assert property (p_needs_input) else $error("output too early");
endmodule

bind mcr_cic_filter mcr_cic_filter_assertions #(.MODE(MODE), .NCH(NCH), .RATE(RATE))
  i_mcr_cic_filter_assertions (.clk(clk), .rst(rst), .input_valid_strobe(input_valid_strobe),
  .ready_for_data(ready_for_data), .out_valid(out_valid), .out_sample(out_sample));

// ---- mcr_src_model.sv ----
`timescale 1ns/1ps
`include "mcr_consts.svh"

module mcr_src_model
  import mcr_pkg::*;
#(
  parameter int NCH    = `MCR_NUM_CH,
  parameter int MAXGAP = 0
)
(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           ready_for_data,
  input  wire logic [NCH-1:0][`MCR_DIN_W-1:0] lvl,
  output logic [`MCR_DIN_W-1:0]               in_sample,
  output logic                                input_valid_strobe
);
  logic [1:0]  ch_r;
  logic [1:0]  nxt;
  int unsigned gap_r;
  int unsigned g_r;

  // Next channel in group order
  assign nxt = (ch_r == 2'(NCH - 1)) ? 2'h0 : ch_r + 2'h1;

  // Idle cycles toggle the last word every cycle, starting with its inverse, so a stale sample cannot pass
  always_ff @(posedge clk)
    if (rst)
    begin
      ch_r <= '0;
      gap_r <= 0;
      g_r <= 0;
      input_valid_strobe <= 1'b0;
      in_sample <= '0;
    end
    else if (input_valid_strobe && ready_for_data)
    begin
      // Gap after this word was drawn at the previous acceptance
      g_r <= $urandom_range(MAXGAP, 0);
      ch_r <= nxt;
      if (g_r == 0)
        in_sample <= lvl[nxt];
      else
      begin
        input_valid_strobe <= 1'b0;
        in_sample <= ~in_sample;
        gap_r <= g_r - 1;
      end
    end
    else if (!input_valid_strobe)
    begin
      if (gap_r == 0)
      begin
        input_valid_strobe <= 1'b1;
        in_sample <= lvl[ch_r];
      end
      else
      begin
        gap_r <= gap_r - 1;
        in_sample <= ~in_sample;
      end
    end
    // Otherwise the offered word is held until ready_for_data is seen high
endmodule

// ---- mcr_cic_filter_tb.sv ----
`timescale 1ns/1ps
`include "mcr_consts.svh"
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module mcr_cic_filter_tb
  import mcr_pkg::*;
  ;
  logic                         clk;
  logic                         rst;
  int                           n_errors;
  int                           check_count;
  logic [3:0][`MCR_DIN_W-1:0]   lvl;
  logic [1:0][`MCR_DIN_W-1:0]   smp;
  logic [1:0]                   stb;
  logic [1:0]                   rdy;
  logic [1:0]                   ov;
  mcr_out_t [1:0]               os;
  logic [1:0][1:0]              ech;
  int                           nout [2];
  logic [1:0]                   run;
  logic                         rdy_low;

  // Instance 0 decimates with a gappy source, instance 1 interpolates with a flooding one
  for (genvar k = 0; k < 2; k++)
  begin : g_dut
    mcr_cic_filter #(.MODE(mcr_mode_t'(k == 0 ? MCR_DECIM : MCR_INTERP))) i_mcr_cic_filter (
      .clk(clk), .rst(rst), .in_sample(smp[k]), .input_valid_strobe(stb[k]),
      .ready_for_data(rdy[k]), .out_valid(ov[k]), .out_sample(os[k]));
    mcr_src_model #(.MAXGAP(k == 0 ? 3 : 0)) i_mcr_src_model (.clk(clk), .rst(rst),
      .ready_for_data(rdy[k]), .lvl(lvl), .in_sample(smp[k]), .input_valid_strobe(stb[k]));
  end

  // Settled DC output: decimator gain cancels the scaling, interpolator keeps 1/RATE
  function automatic logic [`MCR_DIN_W-1:0] exp_out(int k, logic [`MCR_DIN_W-1:0] x);
    return (k == 0) ? x : `MCR_DIN_W'($signed(x) >>> $clog2(`MCR_RATE));
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
    if (!rst)
    begin
      rdy_low = rdy_low | (run[1] & !rdy[1]);
      for (int k = 0; k < 2; k++)
        if (ov[k])
        begin
          `CHK(os[k].chan, ech[k])
          `CHK(os[k].sync, 1'(ech[k] == 2'h0))
          if (nout[k] >= (k == 0 ? 24 : 640))
            `CHK(os[k].data, exp_out(k, lvl[ech[k]]))
          ech[k] = ech[k] + 2'h1;
          nout[k]++;
          run[k] = 1'b1;
        end
        else if (k == 1 && run[1])
          `CHK(ov[1], 1'b1)
    end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(8 * 20000);
    n_errors++;
    conclude();
  end

  initial
  begin
    void'($urandom(4));
    rst = 1'b1;
    n_errors = 0;
    check_count = 0;
    ech = '0;
    nout = '{0, 0};
    run = '0;
    rdy_low = 1'b0;
    // Both rails of the 18-bit range, then two random levels
    lvl[0] = 18'h20000;
    lvl[1] = 18'h1ffff;
    lvl[2] = `MCR_DIN_W'($urandom);
    lvl[3] = `MCR_DIN_W'($urandom);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 15000 && !(nout[0] >= 48 && nout[1] >= 1280); i++)
      @(posedge clk);
    `CHK(1'(nout[0] >= 48 && nout[1] >= 1280), 1'b1)
    `CHK(rdy_low, 1'b1)
    conclude();
  end
endmodule
